/* File: design/apgm_pkg.sv */
package apgm_pkg;

    // ****************************************************************
    // Pin map and widths
    // ****************************************************************
    localparam int unsigned PORT_A_PINS     = 8;
    localparam int unsigned PORT_E_PINS     = 2;
    localparam int unsigned NUM_PINS        = PORT_A_PINS + PORT_E_PINS;
    localparam int unsigned ADDR_W          = 16;
    // Lowest external address line carried by port E pins
    localparam int unsigned PORT_E_ADDR_LO  = 6;
    // Lowest external address line carried by port A pins
    localparam int unsigned PORT_A_ADDR_LO  = 8;
    // First port E bit used for address sharing
    localparam int unsigned PORT_E_BIT_LO   = 2;
    // First port A bit used for address sharing
    localparam int unsigned PORT_A_BIT_LO   = 0;
    localparam int unsigned PORT_E_W        = 16;
    localparam int unsigned PORT_A_W        = 16;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    // Peripheral (address) function selected after reset
    localparam logic [NUM_PINS-1:0] RST_PERIPH_SEL = 10'h3FF;
    localparam logic [NUM_PINS-1:0] RST_DIR_OUT    = 10'h000;
    localparam logic [NUM_PINS-1:0] RST_PULLUP_EN  = 10'h3FF;
    localparam logic [NUM_PINS-1:0] RST_ZERO       = 10'h000;
    // Drive-select reset default: tri-state when the bus is idle
    localparam logic                RST_DRIVE_SEL  = 1'b0;

    // Pin output state
    typedef enum logic [1:0] {
        APGM_PIN_OFF  = 2'b00,
        APGM_PIN_ADDR = 2'b01,
        APGM_PIN_GPIO = 2'b10
    } apgm_pin_state_t;

endpackage : apgm_pkg

/* File: design/apgm_addr_pin_gpio_mux.sv */
`timescale 1ns/1ps
// Summary of operation
// - Shared address pins tri-state while the external bus is idle unless drive-select is 1.
// - In reset every shared pin floats with its pull-up on; after it, each pin follows the peripheral select it is given.
// - In GPIO mode each pin has its own input or output direction.
// - Clearing a pin's pull-up enable bit, indexed by port bit number, turns its pull-up off.
// - Address lines 8..15 map to port A bits 0..7 and lines 6..7 to port E bits 2..3.
module apgm_addr_pin_gpio_mux
    import apgm_pkg::*;
(
    // Clock and reset
    input  wire logic                I_CLK,
    input  wire logic                I_RSTN,
    // External memory interface side
    input  wire logic [ADDR_W-1:0]   I_EMI_ADDR,
    input  wire logic                I_EMI_BUS_ACTIVE,
    input  wire logic                I_BUS_DRIVE_SELECT,
    // Port configuration from the GPIO block
    input  wire logic [PORT_A_W-1:0] I_PORT_A_PERIPH_SEL,
    input  wire logic [PORT_A_W-1:0] I_PORT_A_DIR_OUT,
    input  wire logic [PORT_A_W-1:0] I_PORT_A_DATA_OUT,
    input  wire logic [PORT_A_W-1:0] I_PORT_A_PULLUP_ENABLE,
    input  wire logic [PORT_E_W-1:0] I_PORT_E_PERIPH_SEL,
    input  wire logic [PORT_E_W-1:0] I_PORT_E_DIR_OUT,
    input  wire logic [PORT_E_W-1:0] I_PORT_E_DATA_OUT,
    input  wire logic [PORT_E_W-1:0] I_PORT_E_PULLUP_ENABLE,
    // Pads, pin order: port E bits 2..3 then port A bits 0..7
    input  wire logic [NUM_PINS-1:0] I_PAD_IN,
    output logic      [NUM_PINS-1:0] O_PAD_OUT,
    output logic      [NUM_PINS-1:0] O_PAD_OE,
    output logic      [NUM_PINS-1:0] O_PAD_PULLUP_EN,
    // Read-back of pad levels to the GPIO ports
    output logic      [PORT_A_W-1:0] O_PORT_A_PAD_IN,
    output logic      [PORT_E_W-1:0] O_PORT_E_PAD_IN,
    // Drive-select as currently applied
    output logic                     O_BUS_DRIVE_SELECT
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The pin map is fixed by the package; refuse a map that runs past
    // the port or address widths, since the slices below would then
    // read bits that do not exist and the pads would float silently.
    generate
        if (PORT_E_BIT_LO + PORT_E_PINS > PORT_E_W)
        begin : g_bad_port_e
            $error("port E shared bits fall outside the port width");
        end
        if (PORT_A_BIT_LO + PORT_A_PINS > PORT_A_W)
        begin : g_bad_port_a
            $error("port A shared bits fall outside the port width");
        end
        if (PORT_A_ADDR_LO + PORT_A_PINS > ADDR_W)
        begin : g_bad_addr_a
            $error("port A address lines fall outside the address width");
        end
        if (PORT_E_ADDR_LO + PORT_E_PINS != PORT_A_ADDR_LO)
        begin : g_bad_addr_e
            $error("port E address lines must sit just below port A lines");
        end
    endgenerate

    // ****************************************************************
    // Per-pin mapping
    // ****************************************************************
    // Pin index 0..1 is port E, 2..9 is port A, in address order.
    // Keeping the address order in one vector lets one loop serve
    // every pin; the read-back loops undo it for the port views.
    logic [NUM_PINS-1:0] pin_addr;
    logic [NUM_PINS-1:0] pin_periph;
    logic [NUM_PINS-1:0] pin_dir;
    logic [NUM_PINS-1:0] pin_dat;
    logic [NUM_PINS-1:0] pin_pu;

    // Port E pins carry address lines 6..7
    genvar ge;
    generate
        for (ge = 0; ge < PORT_E_PINS; ge++)
        begin : g_port_e
            assign pin_addr[ge]   = I_EMI_ADDR[PORT_E_ADDR_LO+ge];
            assign pin_periph[ge] = I_PORT_E_PERIPH_SEL[PORT_E_BIT_LO+ge];
            assign pin_dir[ge]    = I_PORT_E_DIR_OUT[PORT_E_BIT_LO+ge];
            assign pin_dat[ge]    = I_PORT_E_DATA_OUT[PORT_E_BIT_LO+ge];
            assign pin_pu[ge]     = I_PORT_E_PULLUP_ENABLE[PORT_E_BIT_LO+ge];
        end
    endgenerate

    // Port A pins carry address lines 8..15
    genvar ga;
    generate
        for (ga = 0; ga < PORT_A_PINS; ga++)
        begin : g_port_a
            assign pin_addr[PORT_E_PINS+ga]   = I_EMI_ADDR[PORT_A_ADDR_LO+ga];
            assign pin_periph[PORT_E_PINS+ga] = I_PORT_A_PERIPH_SEL[PORT_A_BIT_LO+ga];
            assign pin_dir[PORT_E_PINS+ga]    = I_PORT_A_DIR_OUT[PORT_A_BIT_LO+ga];
            assign pin_dat[PORT_E_PINS+ga]    = I_PORT_A_DATA_OUT[PORT_A_BIT_LO+ga];
            assign pin_pu[PORT_E_PINS+ga]     = I_PORT_A_PULLUP_ENABLE[PORT_A_BIT_LO+ga];
        end
    endgenerate

    // ****************************************************************
    // Pin function selection
    // ****************************************************************
    // Decide who owns a pin; used for every pin
    // Priority: address function first, then GPIO output, else float.
    // A pin in address mode never falls back to GPIO data, so a stale
    // GPIO output value cannot leak onto the bus while it is idle.
    // The peripheral select reset default of all ones lives in the
    // port block; this mux simply follows whatever it is given.
    function automatic apgm_pin_state_t pin_state(input logic periph,
                                                 input logic dir_out,
                                                 input logic drive);
        apgm_pin_state_t s;
        s = APGM_PIN_OFF;
        if (periph)
        begin
            // Idle bus floats unless drive-select keeps it driven
            s = drive ? APGM_PIN_ADDR : APGM_PIN_OFF;
        end
        else if (dir_out)
        begin
            s = APGM_PIN_GPIO;
        end
        return s;
    endfunction : pin_state

    logic [NUM_PINS-1:0] out_d, out_q;
    logic [NUM_PINS-1:0] oe_d, oe_q;
    logic [NUM_PINS-1:0] pu_d, pu_q;
    logic [PORT_A_W-1:0] pa_in_d, pa_in_q;
    logic [PORT_E_W-1:0] pe_in_d, pe_in_q;
    logic                drv_d, drv_q;

    // Next pad values; registered so pads see no glitch from the mux
    always_comb
    begin
        apgm_pin_state_t st;
        st      = APGM_PIN_OFF;
        out_d   = RST_ZERO;
        oe_d    = RST_ZERO;
        pu_d    = RST_PULLUP_EN;
        pa_in_d = '0;
        pe_in_d = '0;
        drv_d   = I_BUS_DRIVE_SELECT;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            st = pin_state(pin_periph[i], pin_dir[i],
                           I_EMI_BUS_ACTIVE | I_BUS_DRIVE_SELECT);
            case (st)
                APGM_PIN_ADDR:
                begin
                    out_d[i] = pin_addr[i];
                    oe_d[i]  = 1'b1;
                end
                APGM_PIN_GPIO:
                begin
                    out_d[i] = pin_dat[i];
                    oe_d[i]  = 1'b1;
                end
                default:
                begin
                    out_d[i] = 1'b0;
                    oe_d[i]  = 1'b0;
                end
            endcase
            // Pull-up only matters when not driving, but follows its bit
            pu_d[i] = pin_pu[i];
        end
        for (int j = 0; j < PORT_E_PINS; j++)
        begin
            pe_in_d[PORT_E_BIT_LO+j] = I_PAD_IN[j];
        end
        for (int k = 0; k < PORT_A_PINS; k++)
        begin
            pa_in_d[PORT_A_BIT_LO+k] = I_PAD_IN[PORT_E_PINS+k];
        end
    end

    // ****************************************************************
    // Pad registers
    // ****************************************************************
    // Reset floats pins with pull-ups on, so board lines sit high
    // and no memory sees a strobe before software picks a function.
    // Costs one cycle of latency on every pad change, traded for
    // glitch-free pads.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RSTN)
        begin
            out_q   <= RST_ZERO;
            oe_q    <= RST_ZERO;
            pu_q    <= RST_PULLUP_EN;
            pa_in_q <= '0;
            pe_in_q <= '0;
            drv_q   <= RST_DRIVE_SEL;
        end
        else
        begin
            out_q   <= out_d;
            oe_q    <= oe_d;
            pu_q    <= pu_d;
            pa_in_q <= pa_in_d;
            pe_in_q <= pe_in_d;
            drv_q   <= drv_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Outputs straight from flops
    // Read-back is one cycle behind the pad, like the pad drive
    assign O_PAD_OUT          = out_q;
    assign O_PAD_OE           = oe_q;
    assign O_PAD_PULLUP_EN    = pu_q;
    assign O_PORT_A_PAD_IN    = pa_in_q;
    assign O_PORT_E_PAD_IN    = pe_in_q;
    assign O_BUS_DRIVE_SELECT = drv_q;

endmodule : apgm_addr_pin_gpio_mux

/* File: verif/apgm_mux_properties.sv */
`timescale 1ns/1ps
// ****
// Pin mux port checks
// ****
module apgm_mux_properties
    import apgm_pkg::*;
(
    // Clock, reset, inputs
    input wire logic                I_CLK,
    input wire logic                I_RSTN,
    input wire logic [ADDR_W-1:0]   I_EMI_ADDR,
    input wire logic                I_EMI_BUS_ACTIVE,
    input wire logic                I_BUS_DRIVE_SELECT,
    input wire logic [PORT_A_W-1:0] I_PORT_A_PERIPH_SEL,
    input wire logic [PORT_A_W-1:0] I_PORT_A_DIR_OUT,
    input wire logic [PORT_E_W-1:0] I_PORT_E_PERIPH_SEL,
    input wire logic [PORT_E_W-1:0] I_PORT_E_PULLUP_ENABLE,
    // Outputs
    input wire logic [NUM_PINS-1:0] O_PAD_OUT,
    input wire logic [NUM_PINS-1:0] O_PAD_OE,
    input wire logic [NUM_PINS-1:0] O_PAD_PULLUP_EN,
    input wire logic                O_BUS_DRIVE_SELECT
);
    logic run_q;
    // First edge after release still shows reset values
    always_ff @(posedge I_CLK) run_q <= I_RSTN;
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (!(I_RSTN && run_q));
    chk_reset_pads_off: assert property (disable iff (1'b0)
        !I_RSTN |=> O_PAD_OE == '0 && &O_PAD_PULLUP_EN) else $error("pads live in reset");
    chk_idle_tristate: assert property (I_PORT_A_PERIPH_SEL[0] && !I_EMI_BUS_ACTIVE
        && !I_BUS_DRIVE_SELECT |=> !O_PAD_OE[2]) else $error("idle pin driven");
    chk_drive_addr: assert property (I_PORT_A_PERIPH_SEL[0] && I_BUS_DRIVE_SELECT
        |=> O_PAD_OE[2] && O_PAD_OUT[2] == $past(I_EMI_ADDR[8])) else $error("address a8 wrong");
    chk_e_map: assert property (I_PORT_E_PERIPH_SEL[3] && I_EMI_BUS_ACTIVE
        |=> O_PAD_OE[1] && O_PAD_OUT[1] == $past(I_EMI_ADDR[7])) else $error("address a7 wrong");
    chk_a_map: assert property (I_PORT_A_PERIPH_SEL[7] && I_EMI_BUS_ACTIVE
        |=> O_PAD_OUT[9] == $past(I_EMI_ADDR[15])) else $error("address a15 wrong");
    chk_gpio_dir: assert property (!I_PORT_A_PERIPH_SEL[3]
        |=> O_PAD_OE[5] == $past(I_PORT_A_DIR_OUT[3])) else $error("gpio direction wrong");
    chk_pullup_index: assert property ($changed(I_PORT_E_PULLUP_ENABLE[2])
        |=> O_PAD_PULLUP_EN[0] == $past(I_PORT_E_PULLUP_ENABLE[2])) else $error("pull-up wrong");
    chk_drive_copy: assert property ($rose(I_BUS_DRIVE_SELECT)
        |=> O_BUS_DRIVE_SELECT) else $error("drive-select copy wrong");
    // Main scenarios reached
    cover property (I_EMI_BUS_ACTIVE && I_PORT_A_PERIPH_SEL[0]);
    cover property (!I_PORT_A_PERIPH_SEL[3] && I_PORT_A_DIR_OUT[3]);
    cover property (disable iff (1'b0) !I_RSTN ##1 I_RSTN);
endmodule : apgm_mux_properties

/* File: verif/apgm_ext_mem_model.sv */
`timescale 1ns/1ps
// ****
// Board side of the shared pads
// ****
module apgm_ext_mem_model
    import apgm_pkg::*;
(
    // Clock and pads
    input  wire logic                i_clk,
    input  wire logic [NUM_PINS-1:0] i_pad_out,
    input  wire logic [NUM_PINS-1:0] i_pad_oe,
    input  wire logic [NUM_PINS-1:0] i_pad_pullup_en,
    output logic      [NUM_PINS-1:0] o_pad_level
);
    logic [NUM_PINS-1:0] noise_q = 10'h155;
    // Floating pins wander, so a settled guess never passes
    always_ff @(posedge i_clk) noise_q <= {noise_q[8:0], ~noise_q[9]};
    // Memory only listens; pull-up holds released pins high
    assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & (i_pad_pullup_en | noise_q));
endmodule : apgm_ext_mem_model

/* File: verif/apgm_addr_pin_gpio_mux_tb_top.sv */
`timescale 1ns/1ps
module apgm_addr_pin_gpio_mux_tb_top;
    import apgm_pkg::*;
    logic                clk = 1'b0, rstn = 1'b0, act = 1'b0, drv = 1'b0, drvq;
    logic [15:0]         addr = '0, asel = '1, adir = '0, adat = '0, apu = '1;
    logic [15:0]         esel = '1, edir = '0, edat = '0, epu = '1, arb, erb;
    logic [NUM_PINS-1:0] pin, pout, poe, ppu, lastpin;
    int                  fails = 0, comparisons = 0, seed = 32'h0000_a18a;
    always #2.5 clk = ~clk;
    apgm_addr_pin_gpio_mux dut (.I_CLK(clk), .I_RSTN(rstn), .I_EMI_ADDR(addr),
        .I_EMI_BUS_ACTIVE(act), .I_BUS_DRIVE_SELECT(drv), .I_PORT_A_PERIPH_SEL(asel),
        .I_PORT_A_DIR_OUT(adir), .I_PORT_A_DATA_OUT(adat), .I_PORT_A_PULLUP_ENABLE(apu),
        .I_PORT_E_PERIPH_SEL(esel), .I_PORT_E_DIR_OUT(edir), .I_PORT_E_DATA_OUT(edat),
        .I_PORT_E_PULLUP_ENABLE(epu), .I_PAD_IN(pin), .O_PAD_OUT(pout), .O_PAD_OE(poe),
        .O_PAD_PULLUP_EN(ppu), .O_PORT_A_PAD_IN(arb), .O_PORT_E_PAD_IN(erb),
        .O_BUS_DRIVE_SELECT(drvq));
    apgm_ext_mem_model mem (.i_clk(clk), .i_pad_out(pout), .i_pad_oe(poe),
        .i_pad_pullup_en(ppu), .o_pad_level(pin));
    // Pin order: port E bits 2..3, then port A bits 0..7
    function automatic logic [15:0] pins(input logic [15:0] a, input logic [15:0] e);
        return {6'h00, a[7:0], e[3:2]};
    endfunction : pins
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
        comparisons++;
        if ((got & m) !== (exp & m))
        begin
            fails++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic check_all();
        logic [15:0] s, eoe;
        s = pins(asel, esel);
        eoe = (s & {16{act | drv}}) | (~s & pins(adir, edir));
        cmp({6'h00, poe}, eoe, 16'hffff);
        cmp({6'h00, pout}, (s & {6'h00, addr[15:6]}) | (~s & pins(adat, edat)), eoe);
        cmp({6'h00, ppu}, pins(apu, epu), 16'hffff);
        cmp(arb | {erb[15:4], 2'h0, erb[1:0]}, {8'h00, lastpin[9:2]}, 16'hffff);
        cmp({erb[3:2], drvq}, {lastpin[1:0], drv}, 16'h0007);
    endtask : check_all
    task automatic give_verdict();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        for (int r = 0; r < 2; r++)
        begin
            rstn = 1'b0;
            repeat (3) @(negedge clk);
            cmp({6'h00, pout | poe} | arb | erb, {15'h0000, drvq}, 16'hffff);
            cmp({6'h00, ppu}, 16'h03ff, 16'hffff);
            rstn = 1'b1;
            for (int n = 0; n < 200; n++)
            begin
                @(negedge clk);
                if (n > 1)
                    check_all();
                if (n < 5)
                begin
                    asel = 16'hffff;
                    esel = 16'hffff;
                    act = (n == 3);
                    drv = (n == 4);
                end
                else
                begin
                    {addr, asel, adir, adat} = {$random(seed), $random(seed)};
                    {apu, esel, edir, edat} = {$random(seed), $random(seed)};
                    {epu, act, drv} = 18'($random(seed));
                end
                lastpin = pin;
            end
        end
        give_verdict();
    end
    // Watchdog, far beyond two runs of about 200 cycles
    initial
    begin
        #20000;
        fails++;
        give_verdict();
    end
endmodule : apgm_addr_pin_gpio_mux_tb_top
bind apgm_addr_pin_gpio_mux apgm_mux_properties chk (.*);
